// [hw/pbr_regs.sv]
// pbr_regs: AXI4-Lite register bank holding pressure and baseline references.
// assumes a single aclk, synchronous active-low reset, and a master that
// keeps at most one write and one read in flight.
//
// Operation
// - pressure pair is unsigned, 1 hPa per bit
// - device uses only the pressure shadow copy
// - low byte write loads full shadow value
// - high byte write leaves shadow untouched
// - default pressure means compensation stays off
// - pressure below 750 becomes 750
// - pressure above 1150 becomes 1150
// - out of range write sets command error
// - baseline pair feeds correction and calibration
// - baseline pair is signed, 1 ppm per bit
// - baseline below 350 becomes 350
// - baseline above 1500 becomes 1500
// - scratch byte stores and returns, no effect
// - invalid soft command sets command error
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module pbr_regs
	import pbr_pkg::*;
(
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic [pbr_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [pbr_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [pbr_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [pbr_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic [15:0]                      pressure_shadow,
	output logic                             pressure_comp_on,
	output logic signed [15:0]               baseline_ref,
	output logic                             cmd_strobe,
	output logic [7:0]                       cmd_code,
	output logic                             irq
);
	import pbr_pkg::*;

	// byte address to register index; misaligned low bits are ignored
	function automatic logic [IDX_W-1:0] pbr_idx(input logic [ADDR_W-1:0] a);
		pbr_idx = a[ADDR_W-1:2];
	endfunction

	// true for every index that holds a register
	function automatic logic pbr_mapped(input logic [IDX_W-1:0] i);
		pbr_mapped = (i == IDX_STATUS) || (i == IDX_MASK) ||
			(i == IDX_PRES_HI) || (i == IDX_PRES_LO) ||
			(i == IDX_BASE_HI) || (i == IDX_BASE_LO) ||
			(i == IDX_SCRATCH) || (i == IDX_SOFT_RST);
	endfunction

	// true for the documented soft command codes
	function automatic logic pbr_cmd_ok(input logic [7:0] c);
		pbr_cmd_ok = (c == CMD_SOFT_RESET) || (c == CMD_AUTO_BASELINE_CORRECTION_RESET) ||
			(c == CMD_VDD_OFF) || (c == CMD_SAVE_CAL) ||
			(c == CMD_IIR_OFF) || (c == CMD_FCC_RESET) ||
			(c == CMD_IIR_ON);
	endfunction

	// write channel holding registers
	pbr_wstate_t      wstate;    // idle or answering
	logic             aw_held;   // address taken, waiting for data
	logic [IDX_W-1:0] aw_idx;    // held write index
	logic             w_held;    // data taken, waiting for address
	logic [7:0]       w_byte;    // held low data byte
	logic             w_lane0;   // held strobe for the only used lane

	// visible registers
	logic [7:0]       pres_hi;   // pressure high byte
	logic [7:0]       pres_lo;   // pressure low byte
	logic [7:0]       base_hi;   // baseline high byte
	logic [7:0]       base_lo;   // baseline low byte
	logic [7:0]       scratch;   // integrity test byte
	logic [ST_W-1:0]  status;    // sticky event bits
	logic [ST_W-1:0]  mask;      // interrupt enables

	// write decode
	logic             do_write;  // both halves present, slave idle
	logic             wr_en;     // write with lane 0 enabled
	logic             wr_pres_hi;
	logic             wr_pres_lo;
	logic             wr_base_hi;
	logic             wr_base_lo;
	logic             wr_scratch;
	logic             wr_mask;
	logic             wr_soft;

	// clamp datapath
	logic [15:0]        pres_join;    // stored high byte with new low byte
	logic               pres_lo_err;  // below lower limit
	logic               pres_hi_err;  // above upper limit
	logic [15:0]        pres_clamp;   // value after clamping
	logic signed [15:0] base_join;    // signed baseline candidate
	logic               base_lo_err;
	logic               base_hi_err;
	logic [15:0]        base_clamp;
	logic               cmd_bad;      // soft write with unknown code

	// read path and status update
	logic             rd_take;        // read address handshake
	logic [IDX_W-1:0] rd_idx;
	logic [7:0]       rd_byte;        // selected register byte
	logic [ST_W-1:0]  st_set;         // events this cycle
	logic [ST_W-1:0]  st_clr;         // cleared by a status read
	logic [ST_W-1:0]  next_status;

	// handshakes stay combinational; each side stalls until the answer drains
	assign s_axi_awready = !aw_held && (wstate == PBR_W_IDLE);
	assign s_axi_wready  = !w_held && (wstate == PBR_W_IDLE);
	assign s_axi_bvalid  = (wstate == PBR_W_RESP);
	assign s_axi_arready = !s_axi_rvalid;

	assign do_write   = aw_held && w_held && (wstate == PBR_W_IDLE);
	// a write without lane 0 still answers but changes nothing
	assign wr_en      = do_write && w_lane0;
	assign wr_pres_hi = wr_en && (aw_idx == IDX_PRES_HI);
	assign wr_pres_lo = wr_en && (aw_idx == IDX_PRES_LO);
	assign wr_base_hi = wr_en && (aw_idx == IDX_BASE_HI);
	assign wr_base_lo = wr_en && (aw_idx == IDX_BASE_LO);
	assign wr_scratch = wr_en && (aw_idx == IDX_SCRATCH);
	assign wr_mask    = wr_en && (aw_idx == IDX_MASK);
	assign wr_soft    = wr_en && (aw_idx == IDX_SOFT_RST);

	// pressure pair read as unsigned hPa, checked as a whole on the low write
	assign pres_join   = {pres_hi, w_byte};
	assign pres_lo_err = pres_join < PRES_MIN;
	assign pres_hi_err = pres_join > PRES_MAX;
	assign pres_clamp  = pres_lo_err ? PRES_MIN :
		(pres_hi_err ? PRES_MAX : pres_join);

	// baseline pair read as signed ppm, so negative values clamp low
	assign base_join   = $signed({base_hi, w_byte});
	assign base_lo_err = base_join < $signed(BASE_MIN);
	assign base_hi_err = base_join > $signed(BASE_MAX);
	assign base_clamp  = base_lo_err ? BASE_MIN :
		(base_hi_err ? BASE_MAX : base_join);

	assign cmd_bad = wr_soft && !pbr_cmd_ok(w_byte);

	// event collection; the error bit gathers range errors and invalid commands, not unmapped writes
	assign st_set[ST_CMD_ERR]  = (wr_pres_lo && (pres_lo_err || pres_hi_err)) ||
		(wr_base_lo && (base_lo_err || base_hi_err)) || cmd_bad;
	assign st_set[ST_PRES_LD]  = wr_pres_lo;
	assign st_set[ST_CMD_DONE] = wr_soft && !cmd_bad;

	// a status read clears, but an event in the same cycle is kept
	assign rd_take     = s_axi_arvalid && s_axi_arready;
	assign rd_idx      = pbr_idx(s_axi_araddr);
	assign st_clr      = (rd_take && (rd_idx == IDX_STATUS)) ? status : '0;
	assign next_status = (status & ~st_clr) | st_set;

	// read mux; soft command register always reads zero
	assign rd_byte =
		(rd_idx == IDX_STATUS)  ? {{(8-ST_W){1'b0}}, status} :
		(rd_idx == IDX_MASK)    ? {{(8-ST_W){1'b0}}, mask}   :
		(rd_idx == IDX_PRES_HI) ? pres_hi :
		(rd_idx == IDX_PRES_LO) ? pres_lo :
		(rd_idx == IDX_BASE_HI) ? base_hi :
		(rd_idx == IDX_BASE_LO) ? base_lo :
		(rd_idx == IDX_SCRATCH) ? scratch : 8'h00;

	// device-facing values
	assign baseline_ref     = $signed({base_hi, base_lo});
	// left at its default the reference means no compensation at all
	assign pressure_comp_on = (pressure_shadow != RST_PRES);
	assign irq              = |(status & mask);

	// address and data are caught independently, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_idx  <= '0;
			w_held  <= 1'b0;
			w_byte  <= 8'h00;
			w_lane0 <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_idx  <= pbr_idx(s_axi_awaddr);
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held  <= 1'b1;
				w_byte  <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// write response state; unmapped indices answer with a slave error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wstate      <= PBR_W_IDLE;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			case (wstate)
				PBR_W_IDLE: begin
					if (do_write) begin
						wstate      <= PBR_W_RESP;
						s_axi_bresp <= pbr_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
					end
				end
				PBR_W_RESP: begin
					if (s_axi_bready) begin
						wstate <= PBR_W_IDLE;
					end
				end
				default: begin
					wstate <= PBR_W_IDLE;
				end
			endcase
		end
	end

	// pressure bytes and shadow; only the low write moves the shadow
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pres_hi         <= RST_PRES_HI;
			pres_lo         <= RST_PRES_LO;
			pressure_shadow <= RST_PRES;
		end else if (wr_pres_hi) begin
			pres_hi <= w_byte;
		end else if (wr_pres_lo) begin
			pres_hi         <= pres_clamp[15:8];
			pres_lo         <= pres_clamp[7:0];
			pressure_shadow <= pres_clamp;
		end
	end

	// baseline bytes; the clamped pair is written back on the low write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_hi <= RST_BASE_HI;
			base_lo <= RST_BASE_LO;
		end else if (wr_base_hi) begin
			base_hi <= w_byte;
		end else if (wr_base_lo) begin
			base_hi <= base_clamp[15:8];
			base_lo <= base_clamp[7:0];
		end
	end

	// scratch byte feeds nothing but the read mux
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scratch <= RST_SCRATCH;
		end else if (wr_scratch) begin
			scratch <= w_byte;
		end
	end

	// status, mask and the command strobe to the device core
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status     <= '0;
			mask       <= RST_MASK;
			cmd_strobe <= 1'b0;
			cmd_code   <= 8'h00;
		end else begin
			status     <= next_status;
			cmd_strobe <= wr_soft && !cmd_bad;
			if (wr_mask) begin
				mask <= w_byte[ST_W-1:0];
			end
			if (wr_soft && !cmd_bad) begin
				cmd_code <= w_byte;
			end
		end
	end

	// read channel; one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {{(DATA_W-8){1'b0}}, rd_byte};
			s_axi_rresp  <= pbr_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// checks on the register behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_pres_lo_ok;
		wr_pres_lo && !pres_lo_err && !pres_hi_err;
	endsequence

	sequence s_pres_lo_under;
		wr_pres_lo && pres_lo_err;
	endsequence

	property p_hi_keeps_shadow;
		wr_pres_hi |=> $stable(pressure_shadow);
	endproperty
	a_hi_keeps_shadow: assert property (p_hi_keeps_shadow)
		else $error("shadow moved on high byte write");

	property p_lo_loads_shadow;
		s_pres_lo_ok |=> (pressure_shadow == $past(pres_join));
	endproperty
	a_lo_loads_shadow: assert property (p_lo_loads_shadow)
		else $error("shadow not loaded with joined value");

	property p_pres_clamp_low;
		s_pres_lo_under |=> (pressure_shadow == PRES_MIN) &&
			({pres_hi, pres_lo} == PRES_MIN) && status[ST_CMD_ERR];
	endproperty
	a_pres_clamp_low: assert property (p_pres_clamp_low)
		else $error("low pressure not clamped");

	property p_pres_clamp_high;
		wr_pres_lo && pres_hi_err |=> (pressure_shadow == PRES_MAX) &&
			({pres_hi, pres_lo} == PRES_MAX);
	endproperty
	a_pres_clamp_high: assert property (p_pres_clamp_high)
		else $error("high pressure not clamped");

	property p_shadow_matches_bytes;
		wr_pres_lo |=> (pressure_shadow == {pres_hi, pres_lo});
	endproperty
	a_shadow_matches_bytes: assert property (p_shadow_matches_bytes)
		else $error("bytes and shadow disagree after low write");

	property p_err_sets_flag;
		wr_base_lo && (base_lo_err || base_hi_err) |=> status[ST_CMD_ERR];
	endproperty
	a_err_sets_flag: assert property (p_err_sets_flag)
		else $error("range error did not set flag");

	property p_base_clamp_low;
		wr_base_lo && base_lo_err |=> (baseline_ref == $signed(BASE_MIN));
	endproperty
	a_base_clamp_low: assert property (p_base_clamp_low)
		else $error("low baseline not clamped");

	property p_base_clamp_high;
		wr_base_lo && base_hi_err |=> (baseline_ref == $signed(BASE_MAX));
	endproperty
	a_base_clamp_high: assert property (p_base_clamp_high)
		else $error("high baseline not clamped");

	property p_scratch_store;
		wr_scratch |=> (scratch == $past(w_byte)) ##1 $stable(baseline_ref);
	endproperty
	a_scratch_store: assert property (p_scratch_store)
		else $error("scratch byte not stored");

	property p_bad_cmd_flag;
		cmd_bad |=> status[ST_CMD_ERR] && !cmd_strobe;
	endproperty
	a_bad_cmd_flag: assert property (p_bad_cmd_flag)
		else $error("invalid command not flagged");

	// only a low byte write may move the device off the default reference
	property p_default_comp_off;
		(pressure_shadow == RST_PRES) && !wr_pres_lo |=> !pressure_comp_on;
	endproperty
	a_default_comp_off: assert property (p_default_comp_off)
		else $error("compensation on at default pressure");
endmodule
`default_nettype wire

// [hw/pbr_pkg.sv]
// pbr_pkg: constants for the pressure and baseline reference register bank.
// assumes one aclk domain and an AXI4-Lite register bus with 32-bit data.
package pbr_pkg;
	// bus geometry
	localparam int ADDR_W = 8;                   // byte address width
	localparam int IDX_W  = 6;                   // register index width
	localparam int DATA_W = 32;                  // bus data width

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_STATUS   = 6'h01;  // sticky status, read clears
	localparam logic [5:0] IDX_MASK     = 6'h02;  // interrupt mask
	localparam logic [5:0] IDX_PRES_HI  = 6'h0b;  // pressure reference high byte
	localparam logic [5:0] IDX_PRES_LO  = 6'h0c;  // pressure reference low byte
	localparam logic [5:0] IDX_BASE_HI  = 6'h0d;  // baseline reference high byte
	localparam logic [5:0] IDX_BASE_LO  = 6'h0e;  // baseline reference low byte
	localparam logic [5:0] IDX_SCRATCH  = 6'h0f;  // integrity test byte
	localparam logic [5:0] IDX_SOFT_RST = 6'h10;  // soft reset command, reads zero

	// reset values
	localparam logic [7:0]  RST_PRES_HI = 8'h03;
	localparam logic [7:0]  RST_PRES_LO = 8'hf7;
	localparam logic [15:0] RST_PRES    = {RST_PRES_HI, RST_PRES_LO};
	localparam logic [7:0]  RST_BASE_HI = 8'h01;
	localparam logic [7:0]  RST_BASE_LO = 8'h90;
	localparam logic [7:0]  RST_SCRATCH = 8'h00;
	localparam logic [2:0]  RST_MASK    = 3'h0;

	// valid ranges: pressure in hPa, baseline in ppm
	localparam logic [15:0] PRES_MIN = 16'h02ee;  // 750
	localparam logic [15:0] PRES_MAX = 16'h047e;  // 1150
	localparam logic [15:0] BASE_MIN = 16'h015e;  // 350
	localparam logic [15:0] BASE_MAX = 16'h05dc;  // 1500

	// status bit positions
	localparam int ST_W        = 3;
	localparam int ST_CMD_ERR  = 0;  // command error
	localparam int ST_PRES_LD  = 1;  // shadow pressure loaded
	localparam int ST_CMD_DONE = 2;  // valid soft command taken

	// soft reset command codes
	localparam logic [7:0] CMD_SOFT_RESET = 8'ha3;
	localparam logic [7:0] CMD_AUTO_BASELINE_CORRECTION_RESET = 8'hbc;
	localparam logic [7:0] CMD_VDD_OFF    = 8'hcd;
	localparam logic [7:0] CMD_SAVE_CAL   = 8'hcf;
	localparam logic [7:0] CMD_IIR_OFF    = 8'hdf;
	localparam logic [7:0] CMD_FCC_RESET  = 8'hfc;
	localparam logic [7:0] CMD_IIR_ON     = 8'hfe;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// write channel state
	typedef enum logic [1:0] {
		PBR_W_IDLE = 2'b01,
		PBR_W_RESP = 2'b10
	} pbr_wstate_t;
endpackage

// [tb/pbr_host.sv]
// pbr_host: bus-master model of the host that programs the register bank.
// assumes the bench calls its tasks one at a time, after reset is released.
`timescale 1ns/100ps
`default_nettype none
module pbr_host
	import pbr_pkg::*;
(
	input  wire logic                       aclk,
	output logic [pbr_pkg::ADDR_W-1:0]      awaddr,
	output logic                            awvalid,
	input  wire logic                       awready,
	output logic [pbr_pkg::DATA_W-1:0]      wdata,
	output logic [3:0]                      wstrb,
	output logic                            wvalid,
	input  wire logic                       wready,
	input  wire logic [1:0]                 bresp,
	input  wire logic                       bvalid,
	output logic                            bready,
	output logic [pbr_pkg::ADDR_W-1:0]      araddr,
	output logic                            arvalid,
	input  wire logic                       arready,
	input  wire logic [pbr_pkg::DATA_W-1:0] rdata,
	input  wire logic [1:0]                 rresp,
	input  wire logic                       rvalid,
	output logic                            rready
);
	// idle bus at time zero; only the low byte lane carries register data
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		wstrb = 4'h1;
	end

	// changes the byte lane strobe between transfers, just after an edge
	task automatic set_strb(input logic [3:0] s);
		@(posedge aclk);
		wstrb <= s;
	endtask

	// one write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		// leading edge keeps bready from being assigned twice in one step
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
		// no cycle count assumed: wait for the answer itself
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	// one read: address held until taken, data taken with rvalid
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [tb/pbr_regs_test.sv]
// pbr_regs_test: self-checking bench for the reference register bank.
// assumes pbr_host drives the bus; expectations come from clamp rules.
`timescale 1ns/100ps
`default_nettype none
module pbr_regs_test;
	import pbr_pkg::*;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, comp_on, cmd_strobe, irq;
	logic [7:0]  awaddr, araddr, cmd_code;
	logic [31:0] wdata, rdata, rnd, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] shadow;
	logic signed [15:0] base_ref;
	int          error_cnt, n_compared, strobes, s0;
	// reset table and clamp corners, both ends of each range
	logic [7:0]  rst_a[6] = '{8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h40};
	logic [7:0]  rst_v[6] = '{8'h03, 8'hf7, 8'h01, 8'h90, 8'h00, 8'h00};
	logic [15:0] pc[7] = '{16'h0000, 16'h02ed, 16'h02ee, 16'h03f7, 16'h047e, 16'h047f, 16'hffff};
	logic [15:0] bc[7] = '{16'h8000, 16'h015d, 16'h015e, 16'h05dc, 16'h05dd, 16'h7fff, 16'hffff};
	logic [7:0]  cmds[8] = '{8'ha3, 8'hbc, 8'hcd, 8'hcf, 8'hdf, 8'hfc, 8'hfe, 8'h5a};

	pbr_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pressure_shadow(shadow), .pressure_comp_on(comp_on),
		.baseline_ref(base_ref), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .irq(irq));

	pbr_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// 125 MHz clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// counts command pulses so a doubled or missing pulse shows
	always @(posedge aclk) begin
		if (cmd_strobe === 1'b1) begin
			strobes <= strobes + 1;
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// baseline compares signed, pressure unsigned
	function automatic logic [15:0] clamp(input logic b, input logic [15:0] v);
		if (b) begin
			return ($signed(v) < 16'sd350) ? 16'd350 : ($signed(v) > 16'sd1500) ? 16'd1500 : v;
		end
		return (v < 16'd750) ? 16'd750 : (v > 16'd1150) ? 16'd1150 : v;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic results();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// one 16-bit reference update, high byte first, with a random mask
	task automatic ref_pair(input logic b, input logic [15:0] v);
		logic [7:0]  ha;
		logic [7:0]  m;
		logic [15:0] c;
		logic [15:0] sh0;
		logic [31:0] st;
		ha = b ? 8'h34 : 8'h2c;
		c = clamp(b, v);
		rnd = lfsr(rnd);
		m = {5'h0, rnd[2:0]};
		host.wr(8'h08, m, r);
		sh0 = shadow;
		host.wr(ha, v[15:8], r);
		chk(shadow, sh0, "shadow after high byte");
		host.rd(ha, d, r);
		chk(d, {24'h0, v[15:8]}, "high byte stored");
		host.wr(ha + 8'h04, v[7:0], r);
		host.rd(ha, d, r);
		chk(d, {24'h0, c[15:8]}, "high byte after clamp");
		host.rd(ha + 8'h04, d, r);
		chk(d, {24'h0, c[7:0]}, "low byte after clamp");
		if (b) begin
			chk(base_ref, c, "baseline value");
		end else begin
			chk(shadow, c, "shadow value");
			chk(comp_on, c != 16'h03f7, "compensation");
		end
		st = {29'h0, !b, c != v};
		chk(irq, |(st[2:0] & m[2:0]), "irq level");
		host.rd(8'h04, d, r);
		chk(d, st, "status");
		chk(irq, 1'b0, "irq after clear");
	endtask

	// stops a hung handshake
	initial begin
		repeat (40000) @(posedge aclk);
		error_cnt++;
		results();
	end

	initial begin
		aresetn = 1'b0;
		error_cnt = 0;
		n_compared = 0;
		strobes = 0;
		rnd = 32'h336bb2f7;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		chk(shadow, 16'h03f7, "shadow at reset");
		chk(comp_on, 1'b0, "compensation at reset");
		chk(base_ref, 16'h0190, "baseline at reset");
		for (int i = 0; i < 6; i++) begin
			host.rd(rst_a[i], d, r);
			chk(d, {24'h0, rst_v[i]}, "reset value");
		end
		// scratch must hold data and leave the references alone
		repeat (8) begin
			rnd = lfsr(rnd);
			host.wr(8'h3c, rnd[7:0], r);
			host.rd(8'h3c, d, r);
			chk(d, {24'h0, rnd[7:0]}, "scratch readback");
			chk({base_ref, shadow}, 32'h019003f7, "scratch side effect");
		end
		// a write with lane 0 disabled answers but must leave scratch alone
		host.set_strb(4'h0);
		host.wr(8'h3c, ~rnd[7:0], r);
		chk(r, RESP_OKAY, "lane-less write response");
		host.set_strb(4'h1);
		host.rd(8'h3c, d, r);
		chk(d, {24'h0, rnd[7:0]}, "lane-less write ignored");
		for (int i = 0; i < 7; i++) begin
			ref_pair(1'b0, pc[i]);
			ref_pair(1'b1, bc[i]);
		end
		// random mix of wild and in-range values
		repeat (20) begin
			rnd = lfsr(rnd);
			ref_pair(rnd[31], rnd[16] ? rnd[15:0] : {8'h03, rnd[7:0]});
		end
		foreach (cmds[i]) begin
			s0 = strobes;
			host.wr(8'h40, cmds[i], r);
			@(posedge aclk);
			chk(strobes - s0, i < 7, "command pulse count");
			if (i < 7) begin
				chk(cmd_code, cmds[i], "command code");
			end
			host.rd(8'h04, d, r);
			chk(d, (i < 7) ? 32'h4 : 32'h1, "command status");
			host.rd(8'h40, d, r);
			chk(d, 32'h0, "command reads zero");
		end
		// unmapped place answers with an error and changes nothing
		host.wr(8'hfc, 8'h55, r);
		chk(r, RESP_SLVERR, "unmapped write");
		host.rd(8'hfc, d, r);
		chk(r, RESP_SLVERR, "unmapped read response");
		chk(d, 32'h0, "unmapped read data");
		results();
	end
endmodule
`default_nettype wire
